// File: core/txbp_defs.svh
// Register map, field positions, reset values and timing counts
`ifndef TXBP_DEFS_SVH
`define TXBP_DEFS_SVH

`define TXBP_A_PAGE      15'h0008
`define TXBP_A_MASKS     15'h0012
`define TXBP_A_OUTSEL    15'h0013
`define TXBP_A_IEN_A     15'h0021
`define TXBP_A_IEN_B     15'h0022
`define TXBP_A_IST_A     15'h0025
`define TXBP_A_IST_B     15'h0026
`define TXBP_A_TXCFG     15'h011F
`define TXBP_A_RISE0     15'h0121
`define TXBP_A_RISE1     15'h0122
`define TXBP_A_FALL0     15'h0123
`define TXBP_A_FALL1     15'h0124
`define TXBP_A_UP_LO     15'h0140
`define TXBP_A_UP_HI     15'h0141
`define TXBP_A_DN_LO     15'h0142
`define TXBP_A_DN_HI     15'h0143
`define TXBP_A_BSTATE    15'h0147

`define TXBP_B_MASK_A    6
`define TXBP_B_MASK_B    7
`define TXBP_B_BLANK_IRQ 5
`define TXBP_B_SEL_PWR   6
`define TXBP_B_SEL_TX    5
`define TXBP_B_SEL_SW    3
`define TXBP_B_SW_LEVEL  2
`define TXBP_B_INVERT    2
`define TXBP_F_FALL_HI   7
`define TXBP_F_FALL_LO   6
`define TXBP_F_RISE_HI   5
`define TXBP_F_RISE_LO   4

`define TXBP_RST_PAGE    8'h03
`define TXBP_RST_TXCFG   8'h40
`define TXBP_RST_FALL0   8'h12
`define TXBP_RST_ZERO    8'h00

`define TXBP_STAGE_UNIT  5'h00
`define TXBP_SPI_INSTR   5'h0F
`define TXBP_SPI_LAST    5'h17
`define TXBP_SPI_DATA0   5'h10
`define TXBP_CLK_NS      20
`define TXBP_PWRUP_NS    35000
`define TXBP_PWRUP_CYC \
    ((`TXBP_PWRUP_NS + `TXBP_CLK_NS - 1) / `TXBP_CLK_NS)

`endif

// File: core/txbp_pkg.sv
// Types shared by the transmit-enable blanking protection block
package txbp_pkg;

    typedef enum logic [1:0] {
        TXBP_BS_HOLD = 2'b00,
        TXBP_BS_DOWN = 2'b01,
        TXBP_BS_UP   = 2'b10,
        TXBP_BS_NORM = 2'b11
    } txbp_bsm_t;

    typedef enum logic [1:0] {
        TXBP_TX_LOW     = 2'b00,
        TXBP_TX_RISING  = 2'b01,
        TXBP_TX_HIGH    = 2'b10,
        TXBP_TX_FALLING = 2'b11
    } txbp_ensm_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rise0;
        logic [7:0] rise1;
        logic [7:0] fall0;
        logic [7:0] fall1;
        logic [7:0] up_lo;
        logic [7:0] up_hi;
        logic [7:0] dn_lo;
        logic [7:0] dn_hi;
        logic [7:0] outsel;
    } txbp_dregs_t;

    typedef struct packed {
        logic [2:0]  txen_sync;
        txbp_ensm_t  ens;
        logic        stage;
        logic [12:0] cnt;
        logic        gate;
        logic        gate_d;
        txbp_bsm_t   blanking_fsm;
        logic [15:0] gain;
        logic        pd;
        logic [10:0] pwrup;
        logic        src;
        logic        valid;
        logic        prot;
        logic        flush;
        logic        hold;
    } txbp_dual_t;

    typedef struct packed {
        logic [2:0]  sclk_s;
        logic [2:0]  csn_s;
        logic [1:0]  sdi_s;
        logic [4:0]  bits;
        logic [23:0] sh;
        logic [7:0]  rd;
        logic        rdop;
        logic        sdo;
        logic        sdo_oe;
    } txbp_spi_t;

    typedef struct packed {
        txbp_spi_t         spi;
        logic [7:0]        page;
        logic [7:0]        masks;
        logic [7:0]        ien_a;
        logic [7:0]        ien_b;
        txbp_dregs_t [1:0] regs;
        txbp_dual_t  [1:0] du;
        logic              irq_oe;
    } txbp_state_t;

endpackage

// File: core/txbp_top.sv
// Transmit-enable delay, blanking ramp and protect output, per dual
`timescale 1ns/1ps
`include "txbp_defs.svh"

module txbp_top #(
    parameter int PWRUP_CYCLES = `TXBP_PWRUP_CYC
) (
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    // Serial register port
    input  wire logic                   spi_sclk_in,
    input  wire logic                   spi_csn_in,
    input  wire logic                   spi_sdi_in,
    output logic                        spi_sdo_out,
    output logic                        spi_sdo_oe_out,
    // Transmit enable pins and datapath events
    input  wire logic [1:0]             transmit_enable_pin_in,
    input  wire logic [1:0]             power_limit_flag_in,
    input  wire logic [1:0]             rotation_blank_in,
    input  wire logic [1:0]             rotation_release_in,
    input  wire logic [1:0][15:0]       gain_set_in,
    // Datapath controls
    output logic [1:0][15:0]            gain_out,
    output logic [1:0]                  flush_out,
    output logic [1:0]                  hold_out,
    output logic [1:0]                  dual_powerdown_out,
    output logic [1:0]                  output_valid_out,
    // Protect pins and shared open-drain interrupt
    output logic [1:0]                  protect_output_pin_out,
    output logic                        irq_out,
    output logic                        irq_oe_out
);

    generate
        if (PWRUP_CYCLES < 1 || PWRUP_CYCLES > 2047) begin : g_bad_pwrup
            $error("PWRUP_CYCLES must be within 1..2047");
        end
    endgenerate

    localparam logic [10:0] PWRUP_LOAD = 11'(PWRUP_CYCLES);

    txbp_pkg::txbp_state_t s_r;
    txbp_pkg::txbp_state_t s_nxt;

    function automatic logic [12:0] stage_cycles(input logic [7:0] v);
        stage_cycles = {v, `TXBP_STAGE_UNIT};
    endfunction

    function automatic logic [7:0] rd_reg(input txbp_pkg::txbp_state_t st,
                                          input logic [14:0] a);
        txbp_pkg::txbp_dregs_t dr;
        txbp_pkg::txbp_dual_t  du;
        logic                  live;
        // Reads follow the lower selected page when both are selected
        dr = st.page[0] ? st.regs[0] : st.regs[1];
        du = st.page[0] ? st.du[0] : st.du[1];
        rd_reg = 8'h00;
        unique case (a)
            `TXBP_A_PAGE:   rd_reg = st.page;
            `TXBP_A_MASKS:  rd_reg = st.masks;
            `TXBP_A_OUTSEL: rd_reg = dr.outsel;
            `TXBP_A_IEN_A:  rd_reg = st.ien_a;
            `TXBP_A_IEN_B:  rd_reg = st.ien_b;
            `TXBP_A_IST_A: begin
                live = st.du[0].blanking_fsm == txbp_pkg::TXBP_BS_HOLD ||
                       st.du[0].blanking_fsm == txbp_pkg::TXBP_BS_NORM;
                rd_reg[`TXBP_B_BLANK_IRQ] =
                    st.ien_a[`TXBP_B_BLANK_IRQ] ? st.du[0].src : live;
            end
            `TXBP_A_IST_B: begin
                live = st.du[1].blanking_fsm == txbp_pkg::TXBP_BS_HOLD ||
                       st.du[1].blanking_fsm == txbp_pkg::TXBP_BS_NORM;
                rd_reg[`TXBP_B_BLANK_IRQ] =
                    st.ien_b[`TXBP_B_BLANK_IRQ] ? st.du[1].src : live;
            end
            `TXBP_A_TXCFG:  rd_reg = dr.cfg;
            `TXBP_A_RISE0:  rd_reg = dr.rise0;
            `TXBP_A_RISE1:  rd_reg = dr.rise1;
            `TXBP_A_FALL0:  rd_reg = dr.fall0;
            `TXBP_A_FALL1:  rd_reg = dr.fall1;
            `TXBP_A_UP_LO:  rd_reg = dr.up_lo;
            `TXBP_A_UP_HI:  rd_reg = dr.up_hi;
            `TXBP_A_DN_LO:  rd_reg = dr.dn_lo;
            `TXBP_A_DN_HI:  rd_reg = dr.dn_hi;
            `TXBP_A_BSTATE: rd_reg = {du.blanking_fsm, 6'h00};
            default:        rd_reg = 8'h00;
        endcase
    endfunction

    always_comb begin
        logic        sclk_rise;
        logic        sclk_fall;
        logic [23:0] sh_new;
        logic        we;
        logic [14:0] wa;
        logic [7:0]  wd;
        logic        tx;
        logic        tx_rise;
        logic        tx_fall;
        logic [1:0]  nrise;
        logic [1:0]  nfall;
        logic        mask;
        logic        ien;
        logic        clr;
        logic        done;
        logic [15:0] up_step;
        logic [15:0] dn_step;
        logic [15:0] set;
        logic        gr;
        logic        gf;
        logic        orv;
        txbp_pkg::txbp_dregs_t r;
        s_nxt = s_r;
        we = 1'b0;
        wa = 15'h0000;
        wd = 8'h00;
        sh_new = s_r.spi.sh;
        sclk_rise = s_r.spi.sclk_s[1] & ~s_r.spi.sclk_s[2];
        sclk_fall = ~s_r.spi.sclk_s[1] & s_r.spi.sclk_s[2];
        tx = 1'b0;
        tx_rise = 1'b0;
        tx_fall = 1'b0;
        nrise = 2'd0;
        nfall = 2'd0;
        mask = 1'b0;
        ien = 1'b0;
        clr = 1'b0;
        done = 1'b0;
        up_step = 16'h0000;
        dn_step = 16'h0000;
        set = 16'h0000;
        gr = 1'b0;
        gf = 1'b0;
        orv = 1'b0;
        r = '0;

        // Serial port: pins pass two flip-flops before any decode
        s_nxt.spi.sclk_s = {s_r.spi.sclk_s[1:0], spi_sclk_in};
        s_nxt.spi.csn_s  = {s_r.spi.csn_s[1:0], spi_csn_in};
        s_nxt.spi.sdi_s  = {s_r.spi.sdi_s[0], spi_sdi_in};
        if (s_r.spi.csn_s[1]) begin
            s_nxt.spi.bits   = 5'h00;
            s_nxt.spi.sdo_oe = 1'b0;
        end else begin
            if (sclk_rise && s_r.spi.bits <= `TXBP_SPI_LAST) begin
                sh_new = {s_r.spi.sh[22:0], s_r.spi.sdi_s[1]};
                s_nxt.spi.sh = sh_new;
                s_nxt.spi.bits = 5'(s_r.spi.bits + 5'h01);
                if (s_r.spi.bits == `TXBP_SPI_INSTR) begin
                    s_nxt.spi.rdop = sh_new[15];
                    s_nxt.spi.rd   = rd_reg(s_r, sh_new[14:0]);
                end
                if (s_r.spi.bits == `TXBP_SPI_LAST && !s_r.spi.rdop) begin
                    we = 1'b1;
                    wa = sh_new[22:8];
                    wd = sh_new[7:0];
                end
            end
            if (sclk_fall && s_r.spi.rdop &&
                s_r.spi.bits >= `TXBP_SPI_DATA0 &&
                s_r.spi.bits <= `TXBP_SPI_LAST) begin
                s_nxt.spi.sdo    = s_r.spi.rd[7];
                s_nxt.spi.rd     = {s_r.spi.rd[6:0], 1'b0};
                s_nxt.spi.sdo_oe = 1'b1;
            end
        end

        // Register writes; per-dual copies take every selected page
        if (we) begin
            if (wa == `TXBP_A_PAGE)  s_nxt.page  = wd;
            if (wa == `TXBP_A_MASKS) s_nxt.masks = wd;
            if (wa == `TXBP_A_IEN_A) s_nxt.ien_a = wd;
            if (wa == `TXBP_A_IEN_B) s_nxt.ien_b = wd;
        end
        for (int d = 0; d < 2; d++) begin
            if (we && s_r.page[d]) begin
                unique case (wa)
                    `TXBP_A_OUTSEL: s_nxt.regs[d].outsel = wd;
                    `TXBP_A_TXCFG:  s_nxt.regs[d].cfg    = wd;
                    `TXBP_A_RISE0:  s_nxt.regs[d].rise0  = wd;
                    `TXBP_A_RISE1:  s_nxt.regs[d].rise1  = wd;
                    `TXBP_A_FALL0:  s_nxt.regs[d].fall0  = wd;
                    `TXBP_A_FALL1:  s_nxt.regs[d].fall1  = wd;
                    `TXBP_A_UP_LO:  s_nxt.regs[d].up_lo  = wd;
                    `TXBP_A_UP_HI:  s_nxt.regs[d].up_hi  = wd;
                    `TXBP_A_DN_LO:  s_nxt.regs[d].dn_lo  = wd;
                    `TXBP_A_DN_HI:  s_nxt.regs[d].dn_hi  = wd;
                    default: ;
                endcase
            end
        end

        for (int d = 0; d < 2; d++) begin
            r = s_r.regs[d];
            s_nxt.du[d].txen_sync = {s_r.du[d].txen_sync[1:0],
                                     transmit_enable_pin_in[d]};
            tx      = s_r.du[d].txen_sync[1];
            tx_rise = tx & ~s_r.du[d].txen_sync[2];
            tx_fall = ~tx & s_r.du[d].txen_sync[2];
            // Out-of-range selections clamp to the documented span
            nrise = r.cfg[`TXBP_F_RISE_HI:`TXBP_F_RISE_LO];
            if (nrise > 2'd2) nrise = 2'd2;
            nfall = r.cfg[`TXBP_F_FALL_HI:`TXBP_F_FALL_LO];
            if (nfall == 2'd0) nfall = 2'd1;
            if (nfall > 2'd2) nfall = 2'd2;

            // Transmit-enable machine: gate follows pin after delay
            unique case (s_r.du[d].ens)
                txbp_pkg::TXBP_TX_LOW: begin
                    if (tx_rise) begin
                        if (nrise == 2'd0) begin
                            s_nxt.du[d].gate = 1'b1;
                            s_nxt.du[d].ens  = txbp_pkg::TXBP_TX_HIGH;
                        end else begin
                            s_nxt.du[d].stage = 1'b0;
                            s_nxt.du[d].cnt   = stage_cycles(r.rise0);
                            s_nxt.du[d].ens   = txbp_pkg::TXBP_TX_RISING;
                        end
                    end
                end
                txbp_pkg::TXBP_TX_RISING: begin
                    if (!tx) begin
                        s_nxt.du[d].ens = txbp_pkg::TXBP_TX_LOW;
                    end else if (s_r.du[d].cnt != 13'h0000) begin
                        s_nxt.du[d].cnt = 13'(s_r.du[d].cnt - 13'h0001);
                    end else if (!s_r.du[d].stage && nrise == 2'd2) begin
                        s_nxt.du[d].stage = 1'b1;
                        s_nxt.du[d].cnt   = stage_cycles(r.rise1);
                    end else begin
                        s_nxt.du[d].gate = 1'b1;
                        s_nxt.du[d].ens  = txbp_pkg::TXBP_TX_HIGH;
                    end
                end
                txbp_pkg::TXBP_TX_HIGH: begin
                    if (tx_fall) begin
                        s_nxt.du[d].stage = 1'b0;
                        s_nxt.du[d].cnt   = stage_cycles(r.fall0);
                        s_nxt.du[d].ens   = txbp_pkg::TXBP_TX_FALLING;
                    end
                end
                txbp_pkg::TXBP_TX_FALLING: begin
                    if (tx) begin
                        s_nxt.du[d].ens = txbp_pkg::TXBP_TX_HIGH;
                    end else if (s_r.du[d].cnt != 13'h0000) begin
                        s_nxt.du[d].cnt = 13'(s_r.du[d].cnt - 13'h0001);
                    end else if (!s_r.du[d].stage && nfall == 2'd2) begin
                        s_nxt.du[d].stage = 1'b1;
                        s_nxt.du[d].cnt   = stage_cycles(r.fall1);
                    end else begin
                        s_nxt.du[d].gate = 1'b0;
                        s_nxt.du[d].ens  = txbp_pkg::TXBP_TX_LOW;
                    end
                end
            endcase

            // Power-down on pin fall; power-up wait gates validity
            mask = (d == 0) ? s_r.masks[`TXBP_B_MASK_A]
                            : s_r.masks[`TXBP_B_MASK_B];
            if (tx_fall && mask) begin
                s_nxt.du[d].pd = 1'b1;
            end
            if (tx_rise) begin
                s_nxt.du[d].pd    = 1'b0;
                s_nxt.du[d].pwrup = s_r.du[d].pd ? PWRUP_LOAD : 11'h000;
            end else if (s_r.du[d].pwrup != 11'h000) begin
                s_nxt.du[d].pwrup = 11'(s_r.du[d].pwrup - 11'h001);
            end

            // Blanking machine; a zero step stalls the ramp
            s_nxt.du[d].gate_d = s_r.du[d].gate;
            gr = s_r.du[d].gate & ~s_r.du[d].gate_d;
            gf = ~s_r.du[d].gate & s_r.du[d].gate_d;
            up_step = {r.up_hi, r.up_lo};
            dn_step = {r.dn_hi, r.dn_lo};
            set  = gain_set_in[d];
            done = 1'b0;
            if (gf || rotation_blank_in[d]) begin
                s_nxt.du[d].blanking_fsm = txbp_pkg::TXBP_BS_DOWN;
            end else if (gr || rotation_release_in[d]) begin
                s_nxt.du[d].blanking_fsm = txbp_pkg::TXBP_BS_UP;
            end else begin
                unique case (s_r.du[d].blanking_fsm)
                    txbp_pkg::TXBP_BS_DOWN: begin
                        if (s_r.du[d].gain <= dn_step) begin
                            s_nxt.du[d].gain = 16'h0000;
                            s_nxt.du[d].blanking_fsm  = txbp_pkg::TXBP_BS_HOLD;
                            done = 1'b1;
                        end else begin
                            s_nxt.du[d].gain =
                                16'(s_r.du[d].gain - dn_step);
                        end
                    end
                    txbp_pkg::TXBP_BS_UP: begin
                        if (s_r.du[d].gain >= set ||
                            16'(set - s_r.du[d].gain) <= up_step) begin
                            s_nxt.du[d].gain = set;
                            s_nxt.du[d].blanking_fsm  = txbp_pkg::TXBP_BS_NORM;
                            done = 1'b1;
                        end else begin
                            s_nxt.du[d].gain =
                                16'(s_r.du[d].gain + up_step);
                        end
                    end
                    txbp_pkg::TXBP_BS_NORM: s_nxt.du[d].gain = set;
                    txbp_pkg::TXBP_BS_HOLD: s_nxt.du[d].gain = 16'h0000;
                endcase
            end
            s_nxt.du[d].flush =
                s_nxt.du[d].blanking_fsm == txbp_pkg::TXBP_BS_DOWN ||
                s_nxt.du[d].blanking_fsm == txbp_pkg::TXBP_BS_HOLD;
            s_nxt.du[d].hold =
                s_nxt.du[d].blanking_fsm == txbp_pkg::TXBP_BS_DOWN;

            // Completion source: set beats a same-cycle clear
            ien = (d == 0) ? s_r.ien_a[`TXBP_B_BLANK_IRQ]
                           : s_r.ien_b[`TXBP_B_BLANK_IRQ];
            clr = we && wd[`TXBP_B_BLANK_IRQ] &&
                  wa == ((d == 0) ? `TXBP_A_IST_A : `TXBP_A_IST_B);
            if (!ien) begin
                s_nxt.du[d].src = 1'b0;
            end else if (done) begin
                s_nxt.du[d].src = 1'b1;
            end else if (clr) begin
                s_nxt.du[d].src = 1'b0;
            end

            s_nxt.du[d].valid =
                s_nxt.du[d].blanking_fsm == txbp_pkg::TXBP_BS_NORM &&
                s_nxt.du[d].pwrup == 11'h000 && !s_nxt.du[d].pd;

            orv = (r.outsel[`TXBP_B_SEL_PWR] & power_limit_flag_in[d]) |
                  (r.outsel[`TXBP_B_SEL_TX] & ~s_r.du[d].gate) |
                  (r.outsel[`TXBP_B_SEL_SW] &
                   r.outsel[`TXBP_B_SW_LEVEL]);
            s_nxt.du[d].prot = ~orv ^ r.cfg[`TXBP_B_INVERT];
        end
        s_nxt.irq_oe = s_nxt.du[0].src | s_nxt.du[1].src;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r              <= '0;
            s_r.spi.sclk_s   <= 3'h0;
            s_r.spi.csn_s    <= 3'h7;
            s_r.page         <= `TXBP_RST_PAGE;
            for (int d = 0; d < 2; d++) begin
                s_r.regs[d].cfg   <= `TXBP_RST_TXCFG;
                s_r.regs[d].fall0 <= `TXBP_RST_FALL0;
                s_r.du[d].prot    <= 1'b1;
                s_r.du[d].flush   <= 1'b1;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        spi_sdo_out    = s_r.spi.sdo;
        spi_sdo_oe_out = s_r.spi.sdo_oe;
        irq_out        = 1'b0;
        irq_oe_out     = s_r.irq_oe;
        for (int d = 0; d < 2; d++) begin
            gain_out[d]               = s_r.du[d].gain;
            flush_out[d]              = s_r.du[d].flush;
            hold_out[d]               = s_r.du[d].hold;
            dual_powerdown_out[d]     = s_r.du[d].pd;
            output_valid_out[d]       = s_r.du[d].valid;
            protect_output_pin_out[d] = s_r.du[d].prot;
        end
    end

endmodule // txbp_top

// File: dv/txbp_chk.sv
// Port-level assertions for the blanking protection block
`timescale 1ns/1ps
module txbp_chk (
    // Clock, reset and serial select
    input wire logic             clk_in,
    input wire logic             rst_in,
    input wire logic             spi_csn_in,
    input wire logic             spi_sdo_oe_out,
    // Datapath side
    input wire logic [1:0]       rotation_blank_in,
    input wire logic [1:0][15:0] gain_set_in,
    input wire logic [1:0][15:0] gain_out,
    input wire logic [1:0]       flush_out,
    input wire logic [1:0]       hold_out,
    input wire logic [1:0]       dual_powerdown_out,
    input wire logic [1:0]       output_valid_out,
    input wire logic             irq_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_HOLD_FLUSH: assert property (hold_out[0] |-> flush_out[0])
        else $error("hold without flush");
    AST_HOLD_ZERO: assert property (
        flush_out[0] && !hold_out[0] |-> gain_out[0] == 16'h0000)
        else $error("gain not zero while held");
    AST_RAMP_DOWN: assert property (
        hold_out[0] |=> gain_out[0] <= $past(gain_out[0]))
        else $error("gain rose while ramping down");
    AST_RAMP_UP: assert property (
        !flush_out[0] && !output_valid_out[0]
        |=> flush_out[0] || gain_out[0] >= $past(gain_out[0]))
        else $error("gain fell while ramping up");
    AST_VALID_GAIN: assert property (
        output_valid_out[0] |-> gain_out[0] == gain_set_in[0])
        else $error("valid with gain off target");
    AST_VALID_CLEAN: assert property (
        output_valid_out[0] |-> !flush_out[0] && !dual_powerdown_out[0])
        else $error("valid while blanked or powered down");
    AST_ROT_BLANK: assert property (
        rotation_blank_in[0] && output_valid_out[0] |-> ##[1:3] hold_out[0])
        else $error("rotation did not start ramp down");
    AST_SDO_IDLE: assert property (spi_csn_in [*5] |-> !spi_sdo_oe_out)
        else $error("serial output driven while deselected");
    cover property ($rose(output_valid_out[0]));
    cover property ($rose(hold_out[0]));
    cover property ($rose(irq_oe_out));
endmodule // txbp_chk

// File: dv/txbp_txen_drv.sv
// Transmit-enable source standing in for the baseband logic
`timescale 1ns/1ps
module txbp_txen_drv (
    // Clock and pins
    input  wire logic       clk_in,
    output logic      [1:0] txen_out
);
    initial txen_out = 2'b00;
    // Levels move just after a falling edge, like a registered source
    task automatic drive(input logic [1:0] v);
        @(negedge clk_in);
        txen_out = v;
    endtask
endmodule // txbp_txen_drv

// File: dv/txbp_top_bench.sv
// Self-checking bench for the blanking protection block
`timescale 1ns/1ps
`include "txbp_defs.svh"
module txbp_top_bench;
    logic             clk_in, rst_in, sclk, csn, sdi, sdo, oe, irq, irq_oe;
    logic [1:0]       txen, plim, rblk, rrel, flush, hold, pd, valid, prot;
    logic [1:0][15:0] gset, gain;
    logic [15:0]      rd;
    int               n_fail = 0, checks_done = 0, n;
    txbp_top #(.PWRUP_CYCLES(20)) txbp_top_inst (.clk_in(clk_in),
        .rst_in(rst_in), .spi_sclk_in(sclk), .spi_csn_in(csn),
        .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(oe),
        .transmit_enable_pin_in(txen), .power_limit_flag_in(plim),
        .rotation_blank_in(rblk), .rotation_release_in(rrel),
        .gain_set_in(gset), .gain_out(gain), .flush_out(flush),
        .hold_out(hold), .dual_powerdown_out(pd), .output_valid_out(valid),
        .protect_output_pin_out(prot), .irq_out(irq), .irq_oe_out(irq_oe));
    txbp_txen_drv txbp_txen_drv_inst (.clk_in(clk_in), .txen_out(txen));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Mode 0 frame, eight clocks a phase to clear the pin synchronisers
    task automatic spi(input logic r, input logic [14:0] a,
                       input logic [7:0] wd);
        logic [23:0] f;
        f = {r, a, wd};
        rd = 16'h0000;
        csn = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            repeat (8) @(negedge clk_in);
            sclk = 1'b1;
            repeat (8) @(negedge clk_in);
            if (i < 8) rd[i] = sdo;
            sclk = 1'b0;
        end
        repeat (8) @(negedge clk_in);
        csn = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        spi(1'b0, a, d);
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] m, e);
        spi(1'b1, a, 8'h00);
        chk(rd & {8'h00, m}, {8'h00, e});
    endtask
    function automatic logic cond(input int s);
        case (s)
            0: return valid[0];
            1: return hold[0];
            2: return flush[0] & ~hold[0];
            default: return ~flush[0];
        endcase
    endfunction
    task automatic wt(input int s, input int lim);
        n = 0;
        while (cond(s) !== 1'b1 && n < lim) begin
            @(negedge clk_in);
            n++;
        end
    endtask
    task automatic t_regs();
        rdchk(`TXBP_A_TXCFG, 8'hFF, 8'h40);
        rdchk(`TXBP_A_FALL0, 8'hFF, 8'h12);
        rdchk(15'h0100, 8'hFF, 8'h00);
        wr(`TXBP_A_PAGE, 8'h02);
        wr(`TXBP_A_FALL1, 8'h05);
        rdchk(`TXBP_A_FALL1, 8'hFF, 8'h05);
        wr(`TXBP_A_PAGE, 8'h01);
        rdchk(`TXBP_A_FALL1, 8'hFF, 8'h00);
        wr(`TXBP_A_PAGE, 8'h03);
        wr(`TXBP_A_UP_HI, 8'h01);
        wr(`TXBP_A_DN_HI, 8'h02);
        wr(`TXBP_A_OUTSEL, 8'h20);
        wr(`TXBP_A_IEN_A, 8'h20);
        $display("regs done");
    endtask
    task automatic t_rise();
        txbp_txen_drv_inst.drive(2'b01);
        wt(0, 200);
        chk(16'(n <= 14), 16'h0001);
        chk(gain[0], 16'h0400);
        chk(16'(prot[0]), 16'h0001);
        chk(16'(irq_oe), 16'h0001);
        chk(16'(irq), 16'h0000);
        rdchk(`TXBP_A_IST_A, 8'h20, 8'h20);
        wr(`TXBP_A_IST_A, 8'h20);
        chk(16'(irq_oe), 16'h0000);
        rdchk(`TXBP_A_BSTATE, 8'hC0, 8'hC0);
        $display("rise done");
    endtask
    task automatic t_fall();
        wr(`TXBP_A_MASKS, 8'h40);
        txbp_txen_drv_inst.drive(2'b00);
        wt(1, 700);
        chk(16'(n >= 577 && n <= 586), 16'h0001);
        chk(16'(prot[0]), 16'h0000);
        wt(2, 50);
        chk(gain[0], 16'h0000);
        chk(16'(pd), 16'h0001);
        rdchk(`TXBP_A_BSTATE, 8'hC0, 8'h00);
        wr(`TXBP_A_TXCFG, 8'h44);
        chk(16'(prot[0]), 16'h0001);
        wr(`TXBP_A_TXCFG, 8'h40);
        $display("fall done");
    endtask
    task automatic t_pwrup();
        txbp_txen_drv_inst.drive(2'b01);
        wt(0, 200);
        chk(16'(n >= 20 && n <= 30), 16'h0001);
        chk(16'(pd[0]), 16'h0000);
        $display("power-up done");
    endtask
    task automatic t_stage();
        wr(`TXBP_A_MASKS, 8'h00);
        wr(`TXBP_A_TXCFG, 8'h60);
        wr(`TXBP_A_RISE0, 8'h01);
        wr(`TXBP_A_RISE1, 8'h02);
        txbp_txen_drv_inst.drive(2'b00);
        wt(2, 700);
        txbp_txen_drv_inst.drive(2'b01);
        wt(3, 200);
        chk(16'(n >= 98 && n <= 106), 16'h0001);
        wt(0, 50);
        $display("stages done");
    endtask
    task automatic t_rot();
        @(negedge clk_in);
        rblk = 2'b01;
        @(negedge clk_in);
        rblk = 2'b00;
        wt(2, 50);
        chk(gain[0], 16'h0000);
        rrel = 2'b01;
        @(negedge clk_in);
        rrel = 2'b00;
        wt(0, 50);
        chk(16'(valid[0]), 16'h0001);
        $display("rotation done");
    endtask
    task automatic t_dualb();
        wr(`TXBP_A_MASKS, 8'h80);
        txbp_txen_drv_inst.drive(2'b11);
        repeat (150) @(negedge clk_in);
        chk(gain[1], 16'h0200);
        chk(16'(valid), 16'h0003);
        chk(16'(prot), 16'h0003);
        txbp_txen_drv_inst.drive(2'b01);
        repeat (4) @(negedge clk_in);
        chk(16'(pd), 16'h0002);
        $display("dual B done");
    endtask
    task automatic t_plim();
        wr(`TXBP_A_OUTSEL, 8'h60);
        plim = 2'b01;
        @(negedge clk_in);
        chk(16'(prot[0]), 16'h0000);
        plim = 2'b00;
        @(negedge clk_in);
        chk(16'(prot[0]), 16'h0001);
        wr(`TXBP_A_OUTSEL, 8'h0C);
        chk(16'(prot[0]), 16'h0000);
        $display("protect sources done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {sclk, sdi, plim, rblk, rrel} = 8'h00;
        csn = 1'b1;
        rst_in = 1'b1;
        gset = {16'h0200, 16'h0400};
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        t_regs();
        t_rise();
        t_fall();
        t_pwrup();
        t_stage();
        t_rot();
        t_dualb();
        t_plim();
        give_verdict();
    end
    // Whole run needs about 12300 clocks
    initial begin
        #1ms;
        n_fail++;
        give_verdict();
    end
endmodule // txbp_top_bench
bind txbp_top txbp_chk txbp_chk_inst (.clk_in, .rst_in, .spi_csn_in,
    .spi_sdo_oe_out, .rotation_blank_in, .gain_set_in, .gain_out,
    .flush_out, .hold_out, .dual_powerdown_out, .output_valid_out,
    .irq_oe_out);
